/* rtl/bocr_core.sv */
// Functional notes
// RL1: OR saddr bit into carry, 3B, 5clk
// RL2: OR inverted saddr bit, 3B, 5clk
// RL3: OR sfr bit, plain/inverted, 3B, 7clk
// RL4: OR accumulator bit into carry, 2B, 5clk
// RL5: OR companion register bit, 2B, 5clk
// RL6: OR status word bit, 2B, 5clk
// RL7: XOR saddr bit, 3B, 5clk
// RL8: XOR sfr bit, 3B, 7clk
// RL9: XOR A/X/status bit, 2B, 5clk
// RL10: Set saddr bit, one byte opcode, 3clk
// RL11: Set/clear sfr bit, 3B, 10clk
// RL12: Set/clear A/X bit, 2B, 6clk
// RL13: Status bit set/clear/invert, 2B, 5clk
// RL14: Clear saddr bit, one byte opcode, 3clk
// RL15: Invert saddr bit, 3B, 6clk
// RL16: Invert sfr 10clk, A/X 6clk
// RL17: Carry set/clear/invert, 2clk each
// RL18: Long call pushes PC+3, jumps, 9clk
// RL19: Fixed area call, PC[12:11]=01, 9clk
// RL20: Table call loads PC from table
// RL21: Return pops PC, SP+2, 8clk
// RL22: Interrupt return pops PC, status, SP+3
// RL23: Low three bits pick bit position
// RL24: Carry ops change only carry flag
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "bocr_defines.svh"
module bocr_core (
   input wire logic clk, // Core clock
   input wire logic resetn, // Async reset, low
   input wire bocr_pkg::bocr_instr_t instr, // Opcode bytes
   input wire logic instr_valid, // Instruction offered
   output logic instr_ready_q, // Idle, takes instruction
   output logic done_q, // Last clock of instruction
   output logic illegal_q, // Done with unknown opcode
   output bocr_pkg::bocr_mem_req_t mem_req_q, // Data memory request
   input wire logic [7:0] mem_rdata, // Read byte, next cycle
   input wire logic [2:0] reg_addr, // Register index
   input wire logic [15:0] reg_wdata, // Register write data
   input wire logic reg_we, // Register write strobe
   input wire logic reg_re, // Register read strobe
   output logic [15:0] reg_rdata_q, // Read data
   output logic [15:0] pc_q, // Program counter
   output logic [15:0] sp_q, // Stack pointer
   output logic [7:0] psw_q // Status word
);
   import bocr_pkg::*;

   bocr_state_t state_q;
   logic [3:0] cnt_q;
   bocr_dec_t dec;
   bocr_dec_t dec_q;
   bocr_dec_t d;
   bocr_mem_req_t req_d;
   logic [7:0] rd_q [3];
   logic [7:0] a_q;
   logic [7:0] x_q;
   logic start;
   logic fin;
   logic wr_ok;
   logic [3:0] n;
   logic [15:0] ea;
   logic [15:0] ret_addr;
   logic [15:0] tbl;
   logic [7:0] srcb;
   logic src_bit;
   logic cy_new;
   logic [15:0] tbl_q;
   logic [7:0] dec_q_b0;
   logic [7:0] dec_q_b1;

   // ====================================================
   // Helpers
   function automatic bocr_op_t sub_op(input logic [3:0] s);
      bocr_op_t o;
      case (s)
         `BOCR_SUB_OR: o = OP_OR;
         `BOCR_SUB_ORN: o = OP_ORN;
         `BOCR_SUB_XOR: o = OP_XOR;
         `BOCR_SUB_NOT: o = OP_NOT;
         `BOCR_SUB_SET: o = OP_SET;
         `BOCR_SUB_CLR: o = OP_CLR;
         default: o = OP_ILL;
      endcase
      return o;
   endfunction : sub_op

   // Bit position from the low three bits of the selector
   function automatic logic [7:0] mod_byte(input logic [7:0] b, input logic [2:0] k,
                                           input bocr_op_t o);
      logic [7:0] m;
      m = 8'h01 << k; // RL23
      case (o)
         OP_SET: return b | m;
         OP_CLR: return b & ~m;
         OP_NOT: return b ^ m;
         default: return b;
      endcase
   endfunction : mod_byte

   // ====================================================
   // Decode of the offered opcode bytes
   always_comb begin
      dec.op = OP_ILL;
      dec.dst = DST_CY;
      dec.bitn = instr.b1[2:0]; // RL23
      dec.ofs = instr.b2;
      dec.len = `BOCR_LEN_1;
      dec.lat = `BOCR_LAT_ILL;
      case (instr.b0)
         `BOCR_PFX_MEM: begin
            dec.op = sub_op(instr.b1[7:4]);
            dec.dst = instr.b1[3] ? DST_SFR : DST_SADDR;
            dec.len = `BOCR_LEN_3;
            case (dec.op)
               OP_OR, OP_ORN, OP_XOR: begin
                  // RL1 RL2 RL3 RL7 RL8
                  dec.lat = instr.b1[3] ? `BOCR_LAT_SFR_OR : `BOCR_LAT_SADDR_OR;
               end
               OP_NOT: begin
                  // RL15 RL16
                  dec.lat = instr.b1[3] ? `BOCR_LAT_SFR_MOD : `BOCR_LAT_SADDR_NOT;
               end
               default: begin
                  // RL11; saddr set/clear only exists in its short form
                  dec.lat = `BOCR_LAT_SFR_MOD;
                  if (!instr.b1[3]) dec.op = OP_ILL;
               end
            endcase
         end
         `BOCR_PFX_AX: begin
            dec.op = sub_op(instr.b1[7:4]);
            dec.dst = instr.b1[3] ? DST_A : DST_X; // RL4 RL5
            dec.len = `BOCR_LEN_2;
            if (dec.op inside {OP_OR, OP_ORN, OP_XOR}) dec.lat = `BOCR_LAT_REG_OR; // RL9
            else dec.lat = `BOCR_LAT_AX_MOD; // RL12 RL16
         end
         `BOCR_PFX_PSW: begin
            dec.op = instr.b1[3] ? OP_ILL : sub_op(instr.b1[7:4]);
            dec.dst = DST_PSW;
            dec.len = `BOCR_LEN_2;
            dec.lat = `BOCR_LAT_PSW_MOD; // RL6 RL13
         end
         `BOCR_OPC_CY_SET, `BOCR_OPC_CY_CLR, `BOCR_OPC_CY_NOT: begin
            dec.op = (instr.b0 == `BOCR_OPC_CY_SET) ? OP_SET :
                     (instr.b0 == `BOCR_OPC_CY_CLR) ? OP_CLR : OP_NOT;
            dec.lat = `BOCR_LAT_CY; // RL17
         end
         `BOCR_OPC_CALL: begin
            dec.op = OP_CALL;
            dec.len = `BOCR_LEN_3;
            dec.lat = `BOCR_LAT_CALL; // RL18
         end
         `BOCR_OPC_RET: begin
            dec.op = OP_RET;
            dec.lat = `BOCR_LAT_RET; // RL21
         end
         `BOCR_OPC_INTERRUPT_EXIT: begin
            dec.op = OP_INTERRUPT_EXIT;
            dec.lat = `BOCR_LAT_INTERRUPT_EXIT; // RL22
         end
         default: begin
            if (instr.b0[7:3] == `BOCR_OPH_FIXED_AREA_CALL) begin
               dec.op = OP_FIXED_AREA_CALL;
               dec.len = `BOCR_LEN_2;
               dec.lat = `BOCR_LAT_FIXED_AREA_CALL; // RL19
            end else if (instr.b0[7:3] == `BOCR_OPH_SETS ||
                         instr.b0[7:3] == `BOCR_OPH_CLRS) begin
               // RL10 RL14
               dec.op = (instr.b0[7:3] == `BOCR_OPH_SETS) ? OP_SET : OP_CLR;
               dec.dst = DST_SADDR;
               dec.bitn = instr.b0[2:0];
               dec.ofs = instr.b1;
               dec.len = `BOCR_LEN_2;
               dec.lat = `BOCR_LAT_SADDR_SC;
            end else if (instr.b0[7:5] == `BOCR_OPH_VECTOR_TABLE_CALL) begin
               dec.op = OP_VECTOR_TABLE_CALL;
               dec.lat = `BOCR_LAT_VECTOR_TABLE_CALL; // RL20
            end
         end
      endcase
      // Unknown codes still finish so the fetch side never hangs
      if (dec.op == OP_ILL) begin
         dec.len = `BOCR_LEN_1;
         dec.lat = `BOCR_LAT_ILL;
      end
   end

   // ====================================================
   // Sequencer
   assign start = instr_valid && (state_q == ST_IDLE);
   assign fin = (state_q == ST_RUN) && (cnt_q == dec_q.lat - 4'h1);
   assign wr_ok = reg_we && (state_q == ST_IDLE) && !start;

   // Clock count runs 1..lat; done shows in the last clock
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         instr_ready_q <= 1'b1;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q <= ST_RUN;
                  cnt_q <= 4'h1;
                  instr_ready_q <= 1'b0;
               end
            end
            ST_RUN: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == dec_q.lat) begin
                  state_q <= ST_IDLE;
                  instr_ready_q <= 1'b1;
               end
            end
         endcase
      end
   end

   // Latched decode and completion flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dec_q <= '0;
         done_q <= 1'b0;
         illegal_q <= 1'b0;
      end else begin
         if (start) dec_q <= dec;
         done_q <= fin;
         illegal_q <= fin && (dec_q.op == OP_ILL);
      end
   end

   // ====================================================
   // Data memory schedule, one access per clock
   assign d = start ? dec : dec_q;
   assign n = start ? 4'h1 : cnt_q + 4'h1;
   assign ea = ((d.dst == DST_SFR) ? `BOCR_SFR_BASE : `BOCR_SADDR_BASE) + {8'h00, d.ofs};
   assign ret_addr = pc_q + {14'h0000, d.len};
   assign tbl = `BOCR_TBL_BASE + {10'h000, instr.b0[4:0], 1'b0};

   always_comb begin
      req_d = '0;
      if (start || state_q == ST_RUN) begin
         case (d.op)
            OP_CALL, OP_FIXED_AREA_CALL: begin
               // RL18 RL19: high byte below SP, then low byte
               req_d.we = (n == 4'h1) || (n == 4'h2);
               req_d.addr = sp_q - ((n == 4'h1) ? 16'h0001 : 16'h0002);
               req_d.wdata = (n == 4'h1) ? ret_addr[15:8] : ret_addr[7:0];
            end
            OP_VECTOR_TABLE_CALL: begin
               // RL20: two table reads, then the push
               req_d.re = (n == 4'h1) || (n == 4'h2);
               req_d.we = (n == 4'h3) || (n == 4'h4);
               if (n == 4'h1) req_d.addr = tbl;
               else if (n == 4'h2) req_d.addr = tbl_q + 16'h0001;
               else req_d.addr = sp_q - ((n == 4'h3) ? 16'h0001 : 16'h0002);
               req_d.wdata = (n == 4'h3) ? ret_addr[15:8] : ret_addr[7:0];
            end
            OP_RET, OP_INTERRUPT_EXIT: begin
               // RL21 RL22: low, high, then status for interrupt exit
               req_d.re = (n == 4'h1) || (n == 4'h2) ||
                          ((n == 4'h3) && (d.op == OP_INTERRUPT_EXIT));
               req_d.addr = sp_q + {12'h000, n - 4'h1};
            end
            default: begin
               // Unknown codes touch no memory; a stray register read may have side effects
               if ((d.dst == DST_SADDR || d.dst == DST_SFR) && d.op != OP_ILL) begin
                  // Read at clock 1, write modified byte at clock 3
                  req_d.addr = ea;
                  req_d.re = (n == 4'h1);
                  req_d.we = (n == 4'h3) && (d.op inside {OP_SET, OP_CLR, OP_NOT});
                  req_d.wdata = mod_byte(mem_rdata, d.bitn, d.op); // RL10 RL11 RL14 RL15
               end
            end
         endcase
      end
   end

   // Table address kept for the second table read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) tbl_q <= 16'h0000;
      else if (start) tbl_q <= tbl;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) mem_req_q <= '0;
      else mem_req_q <= req_d;
   end

   // Read bytes arrive in clocks 2..4
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 3; i++) rd_q[i] <= 8'h00;
      end else if (state_q == ST_RUN && cnt_q >= 4'h2 && cnt_q <= 4'h4) begin
         rd_q[cnt_q[1:0] - 2'h2] <= mem_rdata;
      end
   end

   // ====================================================
   // Carry arithmetic
   always_comb begin
      case (dec_q.dst)
         DST_SADDR, DST_SFR: srcb = rd_q[0];
         DST_A: srcb = a_q;
         DST_X: srcb = x_q;
         DST_PSW: srcb = psw_q;
         default: srcb = 8'h00;
      endcase
      src_bit = srcb[dec_q.bitn]; // RL23
      case (dec_q.op)
         OP_OR: cy_new = psw_q[`BOCR_PSW_CY] | src_bit; // RL1 RL4 RL5 RL6
         OP_ORN: cy_new = psw_q[`BOCR_PSW_CY] | ~src_bit; // RL2
         OP_XOR: cy_new = psw_q[`BOCR_PSW_CY] ^ src_bit; // RL7 RL9
         OP_SET: cy_new = 1'b1; // RL17
         OP_CLR: cy_new = 1'b0;
         OP_NOT: cy_new = ~psw_q[`BOCR_PSW_CY];
         default: cy_new = psw_q[`BOCR_PSW_CY];
      endcase
   end

   // ====================================================
   // Status word; only carry moves unless the status word is the target, an interrupt return reloads it or a register write loads it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         psw_q <= `BOCR_RST_PSW;
      end else if (fin) begin
         if (dec_q.op inside {OP_OR, OP_ORN, OP_XOR}) begin
            psw_q[`BOCR_PSW_CY] <= cy_new; // RL24
         end else if (dec_q.op inside {OP_SET, OP_CLR, OP_NOT}) begin
            if (dec_q.dst == DST_CY) psw_q[`BOCR_PSW_CY] <= cy_new; // RL17
            else if (dec_q.dst == DST_PSW) psw_q <= mod_byte(psw_q, dec_q.bitn, dec_q.op); // RL13
         end else if (dec_q.op == OP_INTERRUPT_EXIT) begin
            psw_q <= rd_q[2]; // RL22
         end
      end else if (wr_ok && reg_addr == `BOCR_REG_PSW) begin
         psw_q <= reg_wdata[7:0];
      end
   end

   // Accumulator and companion register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         a_q <= 8'h00;
         x_q <= 8'h00;
      end else if (fin && dec_q.op inside {OP_SET, OP_CLR, OP_NOT}) begin
         if (dec_q.dst == DST_A) a_q <= mod_byte(a_q, dec_q.bitn, dec_q.op); // RL12 RL16
         if (dec_q.dst == DST_X) x_q <= mod_byte(x_q, dec_q.bitn, dec_q.op);
      end else if (wr_ok) begin
         if (reg_addr == `BOCR_REG_A) a_q <= reg_wdata[7:0];
         if (reg_addr == `BOCR_REG_X) x_q <= reg_wdata[7:0];
      end
   end

   // Program flow: counter and stack pointer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pc_q <= `BOCR_RST_PC;
         sp_q <= `BOCR_RST_SP;
      end else if (fin) begin
         case (dec_q.op)
            OP_CALL: begin
               pc_q <= {dec_q.ofs, dec_q_b1}; // RL18
               sp_q <= sp_q - `BOCR_SP_CALL;
            end
            OP_FIXED_AREA_CALL: begin
               pc_q <= {3'h0, `BOCR_FIXED_AREA_CALL_AREA, dec_q_b0[2:0], dec_q_b1}; // RL19
               sp_q <= sp_q - `BOCR_SP_CALL;
            end
            OP_VECTOR_TABLE_CALL: begin
               pc_q <= {rd_q[1], rd_q[0]}; // RL20
               sp_q <= sp_q - `BOCR_SP_CALL;
            end
            OP_RET: begin
               pc_q <= {rd_q[1], rd_q[0]}; // RL21
               sp_q <= sp_q + `BOCR_SP_RET;
            end
            OP_INTERRUPT_EXIT: begin
               pc_q <= {rd_q[1], rd_q[0]}; // RL22
               sp_q <= sp_q + `BOCR_SP_INTERRUPT_EXIT;
            end
            default: pc_q <= pc_q + {14'h0000, dec_q.len};
         endcase
      end else if (wr_ok) begin
         if (reg_addr == `BOCR_REG_PC) pc_q <= reg_wdata;
         if (reg_addr == `BOCR_REG_SP) sp_q <= reg_wdata;
      end
   end

   // Opcode bytes kept for the jump targets
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dec_q_b0 <= 8'h00;
         dec_q_b1 <= 8'h00;
      end else if (start) begin
         dec_q_b0 <= instr.b0;
         dec_q_b1 <= instr.b1;
      end
   end

   // ====================================================
   // Software read port; unmapped reads give zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 16'h0000;
      end else if (reg_re) begin
         case (reg_addr)
            `BOCR_REG_PC: reg_rdata_q <= pc_q;
            `BOCR_REG_SP: reg_rdata_q <= sp_q;
            `BOCR_REG_PSW: reg_rdata_q <= {8'h00, psw_q};
            `BOCR_REG_A: reg_rdata_q <= {8'h00, a_q};
            `BOCR_REG_X: reg_rdata_q <= {8'h00, x_q};
            default: reg_rdata_q <= 16'h0000;
         endcase
      end else begin
         reg_rdata_q <= 16'h0000;
      end
   end

   // ====================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_push2;
      mem_req_q.we ##1 mem_req_q.we;
   endsequence

   a_carry_set: assert property ((start && instr.b0 == `BOCR_OPC_CY_SET) |-> // RL17
      ##2 (done_q && psw_q[`BOCR_PSW_CY])) else $error("carry set timing wrong");
   a_call_push: assert property ((start && instr.b0 == `BOCR_OPC_CALL) |-> // RL18
      ##1 s_push2 ##7 (done_q && sp_q == $past(sp_q, 9) - `BOCR_SP_CALL))
      else $error("long call push or stack wrong");
   a_ret_pop: assert property ((start && instr.b0 == `BOCR_OPC_RET) |-> // RL21
      ##8 (done_q && sp_q == $past(sp_q, 8) + `BOCR_SP_RET)) else $error("return stack wrong");
   a_interrupt_exit_pop: assert property ((start && instr.b0 == `BOCR_OPC_INTERRUPT_EXIT) |-> // RL22
      ##10 (done_q && sp_q == $past(sp_q, 10) + `BOCR_SP_INTERRUPT_EXIT))
      else $error("interrupt return stack wrong");
   a_fixed_area_call_area: assert property ((start && instr.b0[7:3] == `BOCR_OPH_FIXED_AREA_CALL) |-> // RL19
      ##9 (done_q && pc_q[12:11] == `BOCR_FIXED_AREA_CALL_AREA &&
      pc_q[10:0] == {$past(instr.b0[2:0], 9), $past(instr.b1, 9)}))
      else $error("fixed area call target wrong");
   a_set_saddr: assert property ((start && instr.b0[7:3] == `BOCR_OPH_SETS) |-> // RL10
      ##3 (done_q && mem_req_q.we && mem_req_q.wdata[$past(instr.b0[2:0], 3)]))
      else $error("short set write wrong");
   a_clr_saddr: assert property ((start && instr.b0[7:3] == `BOCR_OPH_CLRS) |-> // RL14
      ##3 (done_q && mem_req_q.we && !mem_req_q.wdata[$past(instr.b0[2:0], 3)]))
      else $error("short clear write wrong");
   a_or_keep: assert property ((done_q && dec_q.op inside {OP_OR, OP_ORN, OP_XOR}) |-> // RL24
      ((psw_q & ~`BOCR_PSW_CY_MASK) == ($past(psw_q) & ~`BOCR_PSW_CY_MASK)))
      else $error("carry op touched other flags");
   a_sfr_or_len: assert property ((start && instr.b0 == `BOCR_PFX_MEM && // RL3
      instr.b1[7:4] == `BOCR_SUB_OR && instr.b1[3]) |=> !done_q [*6] ##1 done_q)
      else $error("sfr or duration wrong");
   a_saddr_or_rd: assert property ((start && instr.b0 == `BOCR_PFX_MEM && // RL1
      instr.b1[7:4] == `BOCR_SUB_OR && !instr.b1[3]) |=> mem_req_q.re ##4 done_q)
      else $error("saddr or read or duration wrong");
   a_ax_set_len: assert property ((start && instr.b0 == `BOCR_PFX_AX && // RL12
      instr.b1[7:4] == `BOCR_SUB_SET) |=> !done_q [*5] ##1 done_q)
      else $error("register set duration wrong");
endmodule : bocr_core
`default_nettype wire

/* rtl/bocr_defines.svh */
`ifndef BOCR_DEFINES_SVH
`define BOCR_DEFINES_SVH
// ====================================================
// Opcode bytes and fields
`define BOCR_PFX_MEM 8'h08
`define BOCR_PFX_AX 8'h03
`define BOCR_PFX_PSW 8'h02
`define BOCR_OPC_CY_CLR 8'h40
`define BOCR_OPC_CY_SET 8'h41
`define BOCR_OPC_CY_NOT 8'h42
`define BOCR_OPC_CALL 8'h28
`define BOCR_OPC_RET 8'h56
`define BOCR_OPC_INTERRUPT_EXIT 8'h57
`define BOCR_OPH_FIXED_AREA_CALL 5'h12
`define BOCR_OPH_SETS 5'h16
`define BOCR_OPH_CLRS 5'h14
`define BOCR_OPH_VECTOR_TABLE_CALL 3'h7
`define BOCR_SUB_OR 4'h4
`define BOCR_SUB_ORN 4'h5
`define BOCR_SUB_XOR 4'h6
`define BOCR_SUB_NOT 4'h7
`define BOCR_SUB_SET 4'h8
`define BOCR_SUB_CLR 4'h9
// ====================================================
// Address spaces
`define BOCR_SADDR_BASE 16'hFE00
`define BOCR_SFR_BASE 16'hFF00
`define BOCR_TBL_BASE 16'h0040
`define BOCR_FIXED_AREA_CALL_AREA 2'h1
// ====================================================
// Status word layout and reset values
`define BOCR_PSW_CY 0
`define BOCR_PSW_AC 4
`define BOCR_PSW_Z 6
`define BOCR_PSW_CY_MASK 8'h01
`define BOCR_RST_PC 16'h0000
`define BOCR_RST_SP 16'h0000
`define BOCR_RST_PSW 8'h00
// ====================================================
// Software register indices
`define BOCR_REG_PC 3'h0
`define BOCR_REG_SP 3'h1
`define BOCR_REG_PSW 3'h2
`define BOCR_REG_A 3'h3
`define BOCR_REG_X 3'h4
// ====================================================
// Lengths in bytes and durations in core clocks
`define BOCR_LEN_1 2'h1
`define BOCR_LEN_2 2'h2
`define BOCR_LEN_3 2'h3
`define BOCR_LAT_SADDR_OR 4'h5
`define BOCR_LAT_SFR_OR 4'h7
`define BOCR_LAT_REG_OR 4'h5
`define BOCR_LAT_SADDR_SC 4'h3
`define BOCR_LAT_SADDR_NOT 4'h6
`define BOCR_LAT_SFR_MOD 4'hA
`define BOCR_LAT_AX_MOD 4'h6
`define BOCR_LAT_PSW_MOD 4'h5
`define BOCR_LAT_CY 4'h2
`define BOCR_LAT_CALL 4'h9
`define BOCR_LAT_FIXED_AREA_CALL 4'h9
`define BOCR_LAT_VECTOR_TABLE_CALL 4'hC
`define BOCR_LAT_RET 4'h8
`define BOCR_LAT_INTERRUPT_EXIT 4'hA
`define BOCR_LAT_ILL 4'h2
`define BOCR_SP_CALL 16'h0002
`define BOCR_SP_RET 16'h0002
`define BOCR_SP_INTERRUPT_EXIT 16'h0003
`endif

/* rtl/bocr_pkg.sv */
package bocr_pkg;
   // ====================================================
   // Decoded operation and operand kinds
   typedef enum logic [3:0] {
      OP_OR, OP_ORN, OP_XOR, OP_SET, OP_CLR, OP_NOT,
      OP_CALL, OP_FIXED_AREA_CALL, OP_VECTOR_TABLE_CALL, OP_RET, OP_INTERRUPT_EXIT, OP_ILL
   } bocr_op_t;
   typedef enum logic [2:0] {
      DST_SADDR, DST_SFR, DST_A, DST_X, DST_PSW, DST_CY
   } bocr_dst_t;
   typedef enum logic {ST_IDLE, ST_RUN} bocr_state_t;
   // ====================================================
   // Carriers
   typedef struct packed {
      logic [7:0] b0;
      logic [7:0] b1;
      logic [7:0] b2;
   } bocr_instr_t;
   typedef struct packed {
      bocr_op_t op;
      bocr_dst_t dst;
      logic [2:0] bitn;
      logic [7:0] ofs;
      logic [1:0] len;
      logic [3:0] lat;
   } bocr_dec_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } bocr_mem_req_t;
endpackage : bocr_pkg

/* testbench/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import bocr_pkg::*;
   // ====================================================
   // Stimulus, observed outputs and bench state
   logic clk = 1'b0;
   logic resetn = 1'b0;
   bocr_instr_t instr = '0;
   logic instr_valid = 1'b0;
   logic instr_ready_q, done_q, illegal_q;
   bocr_mem_req_t mem_req_q;
   logic [7:0] mem_rdata = 8'h00;
   logic [2:0] reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic [15:0] reg_rdata_q, pc_q, sp_q, ra;
   logic [7:0] psw_q;
   logic [7:0] mem [0:65535];
   logic [15:0] exp_pc = 16'h1000;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   initial begin
      forever #5 clk = ~clk;
   end
   bocr_core i_dut (.clk(clk), .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
      .instr_ready_q(instr_ready_q), .done_q(done_q), .illegal_q(illegal_q),
      .mem_req_q(mem_req_q), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q),
      .pc_q(pc_q), .sp_q(sp_q), .psw_q(psw_q));
   // ====================================================
   // Data memory: idle data toggles so a stale byte never passes
   always @(posedge clk) begin
      mem_rdata <= mem_req_q.re ? mem[mem_req_q.addr] : ~mem_rdata;
      if (mem_req_q.we) begin
         mem[mem_req_q.addr] <= mem_req_q.wdata;
      end
   end
   // Hang guard, well above the few hundred cycles needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         close_out();
      end
   end
   // ====================================================
   // Tasks
   task automatic close_out;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      @(posedge clk);
      chk("reg", reg_rdata_q, e);
   endtask : rd
   // One edge later so the bench memory has taken the write
   task automatic cm(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      chk("mem", 16'(mem[a]), 16'(e));
   endtask : cm
   // Small nxt is a length, anything larger an absolute target
   task automatic run(input logic [7:0] b0, b1, b2, input int lat, nxt, input logic [7:0] pe);
      int n;
      @(posedge clk);
      chk("ready idle", 16'(instr_ready_q), 16'h0001);
      instr <= {b0, b1, b2};
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (done_q !== 1'b1 && n < 30);
      exp_pc = (nxt < 4) ? exp_pc + 16'(nxt) : 16'(nxt);
      chk("clocks", 16'(n), 16'(lat));
      chk("ready busy", 16'(instr_ready_q), 16'h0000);
      chk("pc", pc_q, exp_pc);
      chk("psw", 16'(psw_q), 16'(pe));
   endtask : run
   // ====================================================
   // Test sequence
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h00;
      end
      mem[16'hFE10] = 8'h01;
      mem[16'h0044] = 8'h78;
      mem[16'h0045] = 8'h56;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(3'(i), 16'h0000);
      end
      $display("test reset done");
      wr(3'h1, 16'h0200);
      wr(3'h0, 16'h1000);
      wr(3'h3, 16'h0004);
      run(8'h41, 8'h00, 8'h00, 2, 1, 8'h01);
      run(8'h40, 8'h00, 8'h00, 2, 1, 8'h00);
      run(8'h42, 8'h00, 8'h00, 2, 1, 8'h01);
      run(8'h40, 8'h00, 8'h00, 2, 1, 8'h00);
      run(8'h02, 8'h86, 8'h00, 5, 2, 8'h40);
      run(8'h03, 8'h4A, 8'h00, 5, 2, 8'h41);
      run(8'h03, 8'h6A, 8'h00, 5, 2, 8'h40);
      run(8'h03, 8'h53, 8'h00, 5, 2, 8'h41);
      run(8'h40, 8'h00, 8'h00, 2, 1, 8'h40);
      run(8'h02, 8'h46, 8'h00, 5, 2, 8'h41);
      run(8'h02, 8'h66, 8'h00, 5, 2, 8'h40);
      run(8'h03, 8'h8F, 8'h00, 6, 2, 8'h40);
      rd(3'h3, 16'h0084);
      run(8'h03, 8'h9A, 8'h00, 6, 2, 8'h40);
      rd(3'h3, 16'h0080);
      run(8'h03, 8'h71, 8'h00, 6, 2, 8'h40);
      rd(3'h4, 16'h0002);
      run(8'h02, 8'h76, 8'h00, 5, 2, 8'h00);
      $display("test register bits done");
      run(8'h08, 8'h40, 8'h10, 5, 3, 8'h01);
      run(8'h40, 8'h00, 8'h00, 2, 1, 8'h00);
      run(8'h08, 8'h51, 8'h10, 5, 3, 8'h01);
      run(8'h08, 8'h60, 8'h10, 5, 3, 8'h00);
      run(8'hB3, 8'h10, 8'h00, 3, 2, 8'h00);
      cm(16'hFE10, 8'h09);
      run(8'hA0, 8'h10, 8'h00, 3, 2, 8'h00);
      cm(16'hFE10, 8'h08);
      run(8'h08, 8'h71, 8'h10, 6, 3, 8'h00);
      cm(16'hFE10, 8'h0A);
      run(8'h08, 8'h8A, 8'h20, 10, 3, 8'h00);
      cm(16'hFF20, 8'h04);
      run(8'h08, 8'h9A, 8'h20, 10, 3, 8'h00);
      cm(16'hFF20, 8'h00);
      run(8'h08, 8'h7D, 8'h20, 10, 3, 8'h00);
      cm(16'hFF20, 8'h20);
      run(8'h08, 8'h4D, 8'h20, 7, 3, 8'h01);
      run(8'h08, 8'h6D, 8'h20, 7, 3, 8'h00);
      run(8'h08, 8'h58, 8'h20, 7, 3, 8'h01);
      $display("test memory bits done");
      ra = exp_pc + 16'h0003;
      run(8'h28, 8'h34, 8'h12, 9, 16'h1234, 8'h01);
      chk("sp", sp_q, 16'h01FE);
      cm(16'h01FF, ra[15:8]);
      cm(16'h01FE, ra[7:0]);
      run(8'h93, 8'h45, 8'h00, 9, 16'h0B45, 8'h01);
      chk("sp", sp_q, 16'h01FC);
      cm(16'h01FD, 8'h12);
      cm(16'h01FC, 8'h36);
      run(8'hE2, 8'h00, 8'h00, 12, 16'h5678, 8'h01);
      chk("sp", sp_q, 16'h01FA);
      cm(16'h01FB, 8'h0B);
      run(8'h56, 8'h00, 8'h00, 8, 16'h0B46, 8'h01);
      chk("sp", sp_q, 16'h01FC);
      mem[16'h01FE] = 8'h55;
      run(8'h57, 8'h00, 8'h00, 10, 16'h1236, 8'h55);
      chk("sp", sp_q, 16'h01FF);
      run(8'h08, 8'h80, 8'h10, 2, 1, 8'h55);
      chk("illegal", 16'(illegal_q), 16'h0001);
      $display("test calls done");
      close_out();
   end
endmodule : tb
`default_nettype wire
